// File: inc/srid_pkg.sv
// constants shared by both ends of the servo remote input link
// assumes a 100 MHz system clock common to both ends
package srid_pkg;
  localparam int SRID_CLOCK_MHZ = 100;
  localparam int SRID_CLEAR_HOLD_MS = 10;
  localparam int SRID_CLEAR_HOLD_CYC = SRID_CLEAR_HOLD_MS * 1000 * SRID_CLOCK_MHZ;
  // droop clear mode and direct specification values
  localparam logic [3:0] SRID_CLR_EDGE = 4'h1;
  localparam logic [3:0] SRID_CLR_LEVEL = 4'h2;
  localparam logic [3:0] SRID_SPEC_REG = 4'h2;
  // response codes, values arbitrary
  localparam logic [15:0] SRID_RESP_OK = 16'h0000;
  localparam logic [15:0] SRID_RESP_BAD_POINT = 16'h0001;
  localparam logic [15:0] SRID_RESP_BAD_SPEC = 16'h0002;
  localparam logic [4:0] SRID_POINT_NONE = 5'h00;
  // controller register byte offsets and the control register reset value
  localparam logic [7:0] SRID_REG_CTRL = 8'h00;
  localparam logic [7:0] SRID_REG_POINT = 8'h04;
  localparam logic [7:0] SRID_REG_CMD4 = 8'h08;
  localparam logic [7:0] SRID_REG_CMD5 = 8'h0C;
  localparam logic [7:0] SRID_REG_CMD6 = 8'h10;
  localparam logic [7:0] SRID_REG_REQ = 8'h14;
  localparam logic [7:0] SRID_REG_STATUS = 8'h18;
  localparam logic [7:0] SRID_REG_IRQ_STAT = 8'h1C;
  localparam logic [7:0] SRID_REG_IRQ_CLR = 8'h20;
  localparam logic [7:0] SRID_REG_IRQ_EN = 8'h24;
  localparam logic [7:0] SRID_CTRL_RESET = 8'h00;
  // control bits
  localparam int SRID_CTRL_TLS = 0;
  localparam int SRID_CTRL_PROP = 1;
  localparam int SRID_CTRL_GAIN = 2;
  localparam int SRID_CTRL_SRC = 3;
  localparam int SRID_CTRL_TUNE_OFF = 4;
  localparam int SRID_CTRL_SPEC2 = 5;
  localparam int SRID_CTRL_AUTO_LOCK = 6;
  localparam int SRID_CTRL_LONG_LOCK = 7;
  // request bits
  localparam int SRID_REQ_POS = 0;
  localparam int SRID_REQ_SPD = 1;
  localparam int SRID_REQ_CLR = 2;
  // interrupt bits
  localparam int SRID_IRQ_POS_ACK = 0;
  localparam int SRID_IRQ_SPD_ACK = 1;
  localparam int SRID_IRQ_MOVE_FALL = 2;
  localparam int SRID_IRQ_CLR_DONE = 3;
  localparam int SRID_IRQ_BITS = 4;
endpackage

// File: inc/srid_link_if.sv
// remote bits and words between the fieldbus master and the servo driver
// both ends run on the same system clock; no tristate signals
`timescale 1ns/100ps
interface srid_link_if;
  logic clearDroop;
  logic positionDemand;
  logic speedDemand;
  logic torqueLimitSelect;
  logic proportionalOnly;
  logic gainSwitch;
  logic commandSourceSelect;
  logic [4:0] pointSelect;
  logic [15:0] commandWord4;
  logic [15:0] commandWord5;
  logic [15:0] commandWord6;
  logic [15:0] responseWord2;
  logic positionAck;
  logic speedAck;
  logic movementDone;
  modport device (
    input clearDroop, positionDemand, speedDemand, torqueLimitSelect, proportionalOnly,
    input gainSwitch, commandSourceSelect, pointSelect, commandWord4, commandWord5, commandWord6,
    output responseWord2, positionAck, speedAck, movementDone
  );
  modport master (
    output clearDroop, positionDemand, speedDemand, torqueLimitSelect, proportionalOnly,
    output gainSwitch, commandSourceSelect, pointSelect, commandWord4, commandWord5, commandWord6,
    input responseWord2, positionAck, speedAck, movementDone
  );
endinterface

// File: verilog/srid_device.sv
// servo driver end: decodes remote bits and command words into settings
// assumes link inputs are synchronous to clock; parameters are static levels
//
// Function
// - mode 1 clears droop once on rising edge
// - master holds clear bit at least 10 ms
// - mode 2 clears droop while bit high
// - position demand takes command words 4 and 5
// - position accept writes response and sets ack
// - speed demand takes command word 6
// - speed accept writes response and sets ack
// - select bit picks internal or forward/reverse limits
// - proportional bit makes speed loop purely proportional
// - master raises proportional bit when movement done falls, drops it once movement done is high again
// - long lock: master adds torque limit select
// - gain switch selects alternate gain set
// - master disables auto tuning before gain switching
// - source off: commands from point select bits
// - source on: commands from command words 4-6
// - register sourcing needs direct spec value 2
//
// The AHB-Lite register port and the placing of the registers were left to the implementer.
`timescale 1ns/100ps
module srid_device
  import srid_pkg::*;
(
  input wire logic clock,
  input wire logic rst_n,
  srid_link_if.device link,
  input wire logic [3:0] droopClearMode,
  input wire logic [3:0] directSpecSelect,
  input wire logic [15:0] forwardTorqueLimit,
  input wire logic [15:0] reverseTorqueLimit,
  input wire logic [15:0] internalTorqueLimit,
  input wire logic [15:0] baseGainSet,
  input wire logic [15:0] alternateGainSet,
  input wire logic motionComplete,
  output logic droopClear,
  output logic [31:0] positionSetting,
  output logic positionIsPoint,
  output logic positionLoad,
  output logic [15:0] speedSetting,
  output logic speedIsPoint,
  output logic speedLoad,
  output logic [15:0] torqueLimitFwd,
  output logic [15:0] torqueLimitRev,
  output logic proportionalMode,
  output logic [15:0] activeGainSet,
  output logic alternateGainActive
);

  typedef struct packed {
    logic clearPrev;
    logic posPrev;
    logic spdPrev;
    logic droopClear;
    logic [31:0] positionSetting;
    logic positionIsPoint;
    logic positionLoad;
    logic [15:0] speedSetting;
    logic speedIsPoint;
    logic speedLoad;
    logic [15:0] response;
    logic positionAck;
    logic speedAck;
    logic movementDone;
    logic [15:0] torqueFwd;
    logic [15:0] torqueRev;
    logic proportional;
    logic [15:0] gainSet;
    logic alternateGain;
  } srid_dev_state_t;

  srid_dev_state_t state;
  srid_dev_state_t next_state;

  // answer code for a command taken from the point bits or from the words
  function automatic logic [15:0] srid_check(
    input logic fromRegisters,
    input logic [3:0] spec,
    input logic [4:0] point
  );
    logic [15:0] code;
    code = SRID_RESP_OK;
    if (fromRegisters) begin
      if (spec != SRID_SPEC_REG) begin
        code = SRID_RESP_BAD_SPEC;
      end
    end else if (point == SRID_POINT_NONE) begin
      code = SRID_RESP_BAD_POINT;
    end
    return code;
  endfunction

  // one rising-edge rule for the clear bit in edge mode and both demand bits, so a
  // level held high can never be taken twice by any of them
  function automatic logic srid_rise(
    input logic level,
    input logic prev
  );
    return level & ~prev;
  endfunction

  logic posRise;
  logic spdRise;
  logic [15:0] posCode;
  logic [15:0] spdCode;

  always_comb begin
    next_state = state;
    next_state.clearPrev = link.clearDroop;
    next_state.posPrev = link.positionDemand;
    next_state.spdPrev = link.speedDemand;
    next_state.positionLoad = 1'b0;
    next_state.speedLoad = 1'b0;
    next_state.movementDone = motionComplete;

    // edge mode gives a single-cycle clear; the master's 10 ms hold only
    // matters to a slow sampler, here any width of one cycle or more works
    case (droopClearMode)
      SRID_CLR_EDGE: begin
        next_state.droopClear = srid_rise(link.clearDroop, state.clearPrev);
      end
      SRID_CLR_LEVEL: begin
        next_state.droopClear = link.clearDroop;
      end
      default: begin
        next_state.droopClear = 1'b0;
      end
    endcase

    posRise = srid_rise(link.positionDemand, state.posPrev);
    spdRise = srid_rise(link.speedDemand, state.spdPrev);
    posCode = srid_check(link.commandSourceSelect, directSpecSelect, link.pointSelect);
    spdCode = srid_check(link.commandSourceSelect, directSpecSelect, link.pointSelect);

    if (posRise) begin
      if (posCode == SRID_RESP_OK) begin
        if (link.commandSourceSelect) begin
          next_state.positionSetting = {link.commandWord5, link.commandWord4};
          next_state.positionIsPoint = 1'b0;
        end else begin
          next_state.positionSetting = {27'h000_0000, link.pointSelect};
          next_state.positionIsPoint = 1'b1;
        end
        next_state.positionLoad = 1'b1;
      end
      next_state.response = posCode;
      next_state.positionAck = 1'b1;
    end else if (!link.positionDemand) begin
      // ack follows the demand back down so the master can re-arm
      next_state.positionAck = 1'b0;
    end

    if (spdRise) begin
      if (spdCode == SRID_RESP_OK) begin
        if (link.commandSourceSelect) begin
          next_state.speedSetting = link.commandWord6;
          next_state.speedIsPoint = 1'b0;
        end else begin
          next_state.speedSetting = {11'h000, link.pointSelect};
          next_state.speedIsPoint = 1'b1;
        end
        next_state.speedLoad = 1'b1;
      end
      // a simultaneous position demand keeps its own code when it failed
      if (!posRise || posCode == SRID_RESP_OK) begin
        next_state.response = spdCode;
      end
      next_state.speedAck = 1'b1;
    end else if (!link.speedDemand) begin
      next_state.speedAck = 1'b0;
    end

    if (link.torqueLimitSelect) begin
      next_state.torqueFwd = internalTorqueLimit;
      next_state.torqueRev = internalTorqueLimit;
    end else begin
      next_state.torqueFwd = forwardTorqueLimit;
      next_state.torqueRev = reverseTorqueLimit;
    end

    next_state.proportional = link.proportionalOnly;
    next_state.alternateGain = link.gainSwitch;
    next_state.gainSet = link.gainSwitch ? alternateGainSet : baseGainSet;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= '0;
      state.response <= SRID_RESP_OK;
    end else begin
      state <= next_state;
    end
  end

  assign droopClear = state.droopClear;
  assign positionSetting = state.positionSetting;
  assign positionIsPoint = state.positionIsPoint;
  assign positionLoad = state.positionLoad;
  assign speedSetting = state.speedSetting;
  assign speedIsPoint = state.speedIsPoint;
  assign speedLoad = state.speedLoad;
  assign torqueLimitFwd = state.torqueFwd;
  assign torqueLimitRev = state.torqueRev;
  assign proportionalMode = state.proportional;
  assign activeGainSet = state.gainSet;
  assign alternateGainActive = state.alternateGain;
  assign link.responseWord2 = state.response;
  assign link.positionAck = state.positionAck;
  assign link.speedAck = state.speedAck;
  assign link.movementDone = state.movementDone;

endmodule

// File: verilog/srid_master.sv
// fieldbus master end: software drives remote bits and words over AHB-Lite
// assumes a single AHB-Lite master, word transfers only, zero wait states
`timescale 1ns/100ps
module srid_master
  import srid_pkg::*;
#(
  parameter int CLEAR_HOLD_CYC = SRID_CLEAR_HOLD_CYC
)
(
  input wire logic clock,
  input wire logic rst_n,
  input wire logic hsel,
  input wire logic [31:0] haddr,
  input wire logic [1:0] htrans,
  input wire logic hwrite,
  input wire logic [2:0] hsize,
  input wire logic [31:0] hwdata,
  input wire logic hready,
  output logic hreadyout,
  output logic hresp,
  output logic [31:0] hrdata,
  output logic irq,
  srid_link_if.master link
);

  typedef struct packed {
    logic dataWrite;
    logic [7:0] dataAddr;
    logic [31:0] rdata;
    logic [7:0] ctrl;
    logic [4:0] point;
    logic [15:0] cmd4;
    logic [15:0] cmd5;
    logic [15:0] cmd6;
    logic posReq;
    logic spdReq;
    logic clearActive;
    logic [19:0] clearCount;
    logic autoProp;
    logic autoTls;
    logic posAckPrev;
    logic spdAckPrev;
    logic movePrev;
    logic [SRID_IRQ_BITS-1:0] irqStatus;
    logic [SRID_IRQ_BITS-1:0] irqEnable;
  } srid_mst_state_t;

  srid_mst_state_t state;
  srid_mst_state_t next_state;
  logic addrPhase;
  logic [SRID_IRQ_BITS-1:0] events;
  logic [SRID_IRQ_BITS-1:0] clearMask;

  always_comb begin
    next_state = state;
    clearMask = '0;
    addrPhase = hsel & htrans[1] & hready;
    events = '0;
    if (addrPhase) begin
      next_state.dataWrite = hwrite;
      next_state.dataAddr = haddr[7:0];
      case (haddr[7:0])
        SRID_REG_CTRL: next_state.rdata = {24'h00_0000, state.ctrl};
        SRID_REG_POINT: next_state.rdata = {27'h000_0000, state.point};
        SRID_REG_CMD4: next_state.rdata = {16'h0000, state.cmd4};
        SRID_REG_CMD5: next_state.rdata = {16'h0000, state.cmd5};
        SRID_REG_CMD6: next_state.rdata = {16'h0000, state.cmd6};
        SRID_REG_STATUS: next_state.rdata = {link.responseWord2, 9'h000, state.clearActive,
          state.spdReq, state.posReq, link.movementDone, link.speedAck, link.positionAck, 1'b0};
        SRID_REG_IRQ_STAT: next_state.rdata = {28'h000_0000, state.irqStatus};
        SRID_REG_IRQ_EN: next_state.rdata = {28'h000_0000, state.irqEnable};
        default: next_state.rdata = 32'h0000_0000;
      endcase
    end else begin
      next_state.dataWrite = 1'b0;
    end

    // demands are held until the device acknowledges, then dropped so the
    // next request makes a fresh rising edge
    if (state.posReq && link.positionAck) begin
      next_state.posReq = 1'b0;
    end
    if (state.spdReq && link.speedAck) begin
      next_state.spdReq = 1'b0;
    end
    if (state.clearActive) begin
      if (state.clearCount == 20'(CLEAR_HOLD_CYC - 1)) begin
        next_state.clearActive = 1'b0;
        events[SRID_IRQ_CLR_DONE] = 1'b1;
      end else begin
        next_state.clearCount = state.clearCount + 20'h0_0001;
      end
    end

    next_state.posAckPrev = link.positionAck;
    next_state.spdAckPrev = link.speedAck;
    next_state.movePrev = link.movementDone;
    events[SRID_IRQ_POS_ACK] = link.positionAck & ~state.posAckPrev;
    events[SRID_IRQ_SPD_ACK] = link.speedAck & ~state.spdAckPrev;
    events[SRID_IRQ_MOVE_FALL] = state.movePrev & ~link.movementDone;
    if (events[SRID_IRQ_MOVE_FALL] && state.ctrl[SRID_CTRL_AUTO_LOCK]) begin
      next_state.autoProp = 1'b1;
      next_state.autoTls = state.ctrl[SRID_CTRL_LONG_LOCK];
    end else if (link.movementDone) begin
      next_state.autoProp = 1'b0;
      next_state.autoTls = 1'b0;
    end

    if (state.dataWrite) begin
      case (state.dataAddr)
        SRID_REG_CTRL: next_state.ctrl = hwdata[7:0];
        SRID_REG_POINT: next_state.point = hwdata[4:0];
        SRID_REG_CMD4: next_state.cmd4 = hwdata[15:0];
        SRID_REG_CMD5: next_state.cmd5 = hwdata[15:0];
        SRID_REG_CMD6: next_state.cmd6 = hwdata[15:0];
        SRID_REG_REQ: begin
          // a request while the same one is pending is ignored
          if (hwdata[SRID_REQ_POS] && !state.posReq && !link.positionAck) begin
            next_state.posReq = 1'b1;
          end
          if (hwdata[SRID_REQ_SPD] && !state.spdReq && !link.speedAck) begin
            next_state.spdReq = 1'b1;
          end
          if (hwdata[SRID_REQ_CLR] && !state.clearActive) begin
            next_state.clearActive = 1'b1;
            next_state.clearCount = 20'h0_0000;
          end
        end
        SRID_REG_IRQ_CLR: clearMask = hwdata[SRID_IRQ_BITS-1:0];
        SRID_REG_IRQ_EN: next_state.irqEnable = hwdata[SRID_IRQ_BITS-1:0];
        default: begin
        end
      endcase
    end
    // a new event wins over a clear in the same cycle
    next_state.irqStatus = (state.irqStatus & ~clearMask) | events;
  end

  always_ff @(posedge clock) begin
    if (!rst_n) begin
      state <= '0;
      state.ctrl <= SRID_CTRL_RESET;
    end else begin
      state <= next_state;
    end
  end

  assign hreadyout = 1'b1;
  assign hresp = 1'b0;
  assign hrdata = state.rdata;
  assign irq = |(state.irqStatus & state.irqEnable);
  assign link.clearDroop = state.clearActive;
  assign link.positionDemand = state.posReq;
  assign link.speedDemand = state.spdReq;
  assign link.torqueLimitSelect = state.ctrl[SRID_CTRL_TLS] | state.autoTls;
  assign link.proportionalOnly = state.ctrl[SRID_CTRL_PROP] | state.autoProp;
  // gain switching is withheld until software confirms auto tuning is off
  assign link.gainSwitch = state.ctrl[SRID_CTRL_GAIN] & state.ctrl[SRID_CTRL_TUNE_OFF];
  // register sourcing only once software confirms the driver is set up for it
  assign link.commandSourceSelect = state.ctrl[SRID_CTRL_SRC] & state.ctrl[SRID_CTRL_SPEC2];
  assign link.pointSelect = state.point;
  assign link.commandWord4 = state.cmd4;
  assign link.commandWord5 = state.cmd5;
  assign link.commandWord6 = state.cmd6;

endmodule

// File: verification/srid_link_props.sv
// checker for the remote link joining the master end and the device end
// watches the shared link signals only; one clock, synchronous active-low reset
`timescale 1ns/100ps
module srid_link_props #(
  parameter int CLEAR_HOLD_CYC = 20
) (
  input wire logic clock,
  input wire logic rst_n,
  input wire logic clearDroop,
  input wire logic positionDemand,
  input wire logic speedDemand,
  input wire logic [15:0] responseWord2,
  input wire logic positionAck,
  input wire logic speedAck
);
  int holdCnt;
  always_ff @(posedge clock) begin
    if (!rst_n || !clearDroop) begin
      holdCnt <= 0;
    end else begin
      holdCnt <= holdCnt + 1;
    end
  end
  default clocking @(posedge clock); endclocking
  default disable iff (!rst_n);
  property p_pos_ack; $rose(positionDemand) |=> positionAck; endproperty
  property p_spd_ack; $rose(speedDemand) |=> speedAck; endproperty
  property p_pos_edge; $rose(positionAck) |-> $past(positionDemand) && !$past(positionDemand, 2); endproperty
  property p_spd_edge; $rose(speedAck) |-> $past(speedDemand) && !$past(speedDemand, 2); endproperty
  property p_pos_drop; !positionDemand |-> ##[1:2] !positionAck; endproperty
  property p_spd_drop; !speedDemand |-> ##[1:2] !speedAck; endproperty
  property p_resp; $changed(responseWord2) |-> $rose(positionAck) || $rose(speedAck); endproperty
  // a reset cut short mid-hold would look like an early release
  property p_clr_hold; $fell(clearDroop) && $past(rst_n) |-> holdCnt >= CLEAR_HOLD_CYC; endproperty
  a_pos_ack: assert property (p_pos_ack) else $error("position ack late");
  a_spd_ack: assert property (p_spd_ack) else $error("speed ack late");
  a_pos_edge: assert property (p_pos_edge) else $error("position ack without rise");
  a_spd_edge: assert property (p_spd_edge) else $error("speed ack without rise");
  a_pos_drop: assert property (p_pos_drop) else $error("position ack stuck");
  a_spd_drop: assert property (p_spd_drop) else $error("speed ack stuck");
  a_resp: assert property (p_resp) else $error("response changed without ack");
  a_clr_hold: assert property (p_clr_hold) else $error("clear bit released early");
  c_pos: cover property ($rose(positionAck));
  c_spd: cover property ($rose(speedAck));
  c_clr: cover property ($fell(clearDroop));
endmodule

// File: verification/test_servo_remote_input_decoder.sv
// self-checking bench: software writes the master over AHB-Lite, device decodes
// both ends share one 100 MHz clock; static device settings are bench variables
`timescale 1ns/100ps
module test_servo_remote_input_decoder
  import srid_pkg::*;
;
  localparam int HOLD = 20;
  localparam logic [15:0] FWD = 16'h0111;
  localparam logic [15:0] REV = 16'h0222;
  localparam logic [15:0] INL = 16'h0333;
  localparam logic [15:0] BASE = 16'h0444;
  localparam logic [15:0] ALT = 16'h0555;
  logic clock = 1'b0;
  logic rst_n = 1'b0;
  logic hsel = 1'b0;
  logic hwrite = 1'b0;
  logic [31:0] haddr = '0;
  logic [31:0] hwdata = '0;
  logic [1:0] htrans = '0;
  logic [2:0] hsize = 3'h2;
  logic [3:0] droopMode = '0;
  logic [3:0] specSel = '0;
  logic motion = 1'b0;
  logic hreadyout, hresp, irq, droopClear, posIsPt, posLoad, spdIsPt, spdLoad, propMode, altActive;
  logic [31:0] hrdata, posSet, posCap, spdCap;
  logic [15:0] spdSet, tlFwd, tlRev, gainSet;
  logic posPtCap, spdPtCap;
  int failCount = 0;
  int checksDone = 0;
  int posLoads = 0;
  int spdLoads = 0;
  int dcHigh = 0;
  int linkHigh = 0;
  srid_link_if link();
  srid_device u_srid_device (.clock(clock), .rst_n(rst_n), .link(link), .droopClearMode(droopMode),
    .directSpecSelect(specSel), .forwardTorqueLimit(FWD), .reverseTorqueLimit(REV),
    .internalTorqueLimit(INL), .baseGainSet(BASE), .alternateGainSet(ALT), .motionComplete(motion),
    .droopClear(droopClear), .positionSetting(posSet), .positionIsPoint(posIsPt), .positionLoad(posLoad),
    .speedSetting(spdSet), .speedIsPoint(spdIsPt), .speedLoad(spdLoad), .torqueLimitFwd(tlFwd),
    .torqueLimitRev(tlRev), .proportionalMode(propMode), .activeGainSet(gainSet),
    .alternateGainActive(altActive));
  srid_master #(.CLEAR_HOLD_CYC(HOLD)) u_srid_master (.clock(clock), .rst_n(rst_n), .hsel(hsel),
    .haddr(haddr), .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata),
    .hready(hreadyout), .hreadyout(hreadyout), .hresp(hresp), .hrdata(hrdata), .irq(irq), .link(link));
  srid_link_props #(.CLEAR_HOLD_CYC(HOLD)) u_srid_link_props (.clock(clock), .rst_n(rst_n),
    .clearDroop(link.clearDroop), .positionDemand(link.positionDemand), .speedDemand(link.speedDemand),
    .responseWord2(link.responseWord2), .positionAck(link.positionAck), .speedAck(link.speedAck));
  initial begin
    forever #5 clock = ~clock;
  end
  // load pulses last one cycle, so they are caught here rather than polled
  always @(posedge clock) begin
    if (posLoad === 1'b1) begin
      posLoads++;
      posCap = posSet;
      posPtCap = posIsPt;
    end
    if (spdLoad === 1'b1) begin
      spdLoads++;
      spdCap = 32'(spdSet);
      spdPtCap = spdIsPt;
    end
    dcHigh += int'(droopClear === 1'b1);
    linkHigh += int'(link.clearDroop === 1'b1);
  end
  task automatic chk(input logic [31:0] got, input logic [31:0] exp);
    checksDone++;
    if (got !== exp) begin
      failCount++;
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic cyc(input int n);
    repeat (n) @(posedge clock);
  endtask
  task automatic bus(input logic w, input logic [7:0] a, input logic [31:0] d, output logic [31:0] r);
    hsel <= 1'b1;
    haddr <= 32'(a);
    hwrite <= w;
    hsize <= 3'h2;
    htrans <= 2'h2;
    do @(posedge clock); while (hreadyout !== 1'b1);
    htrans <= 2'h0;
    hwdata <= d;
    do @(posedge clock); while (hreadyout !== 1'b1);
    r = hrdata;
  endtask
  task automatic wr(input logic [7:0] a, input logic [31:0] d);
    logic [31:0] r;
    bus(1'b1, a, d, r);
  endtask
  task automatic rdChk(input logic [7:0] a, input logic [31:0] m, input logic [31:0] exp);
    logic [31:0] r;
    bus(1'b0, a, '0, r);
    chk(r & m, exp);
  endtask
  task automatic tReset;
    rdChk(SRID_REG_STATUS, 32'hFFFF_FFFF, '0);
    rdChk(SRID_REG_CTRL, 32'hFFFF_FFFF, '0);
    wr(8'h40, 32'h1234_5678);
    rdChk(8'h40, 32'hFFFF_FFFF, '0);
    chk(32'(tlFwd), 32'(FWD));
    chk(32'(tlRev), 32'(REV));
    chk(32'(hresp), 0);
  endtask
  task automatic tPosPoint;
    int n;
    n = posLoads;
    wr(SRID_REG_IRQ_EN, 32'h0000_0003);
    wr(SRID_REG_POINT, 32'h0000_0005);
    wr(SRID_REG_REQ, 32'h0000_0001);
    cyc(8);
    chk(32'(posLoads - n), 1);
    chk(posCap, 32'h0000_0005);
    chk(32'(posPtCap), 1);
    chk(32'(irq), 1);
    rdChk(SRID_REG_STATUS, 32'hFFFF_0000, '0);
    wr(SRID_REG_IRQ_CLR, 32'h0000_000F);
    cyc(2);
    chk(32'(irq), 0);
  endtask
  task automatic tRegSource;
    int n;
    int m;
    specSel <= SRID_SPEC_REG;
    wr(SRID_REG_CTRL, 32'h0000_0028);
    wr(SRID_REG_CMD4, 32'h0000_1234);
    wr(SRID_REG_CMD5, 32'h0000_ABCD);
    wr(SRID_REG_CMD6, 32'h0000_5678);
    n = posLoads;
    m = spdLoads;
    // the second request lands while the first is still pending
    wr(SRID_REG_REQ, 32'h0000_0001);
    wr(SRID_REG_REQ, 32'h0000_0001);
    cyc(8);
    chk(32'(posLoads - n), 1);
    chk(posCap, 32'hABCD_1234);
    chk(32'(posPtCap), 0);
    wr(SRID_REG_REQ, 32'h0000_0002);
    cyc(8);
    chk(32'(spdLoads - m), 1);
    chk(spdCap, 32'h0000_5678);
    chk(32'(spdPtCap), 0);
    rdChk(SRID_REG_STATUS, 32'hFFFF_0000, '0);
    // both demands raised on one edge are each taken once
    wr(SRID_REG_REQ, 32'h0000_0003);
    cyc(8);
    chk(32'(posLoads - n), 2);
    chk(32'(spdLoads - m), 2);
  endtask
  task automatic tErrors;
    int n;
    n = posLoads + spdLoads;
    wr(SRID_REG_CTRL, '0);
    wr(SRID_REG_POINT, '0);
    wr(SRID_REG_REQ, 32'h0000_0001);
    cyc(8);
    rdChk(SRID_REG_STATUS, 32'hFFFF_0000, 32'h0001_0000);
    specSel <= 4'h1;
    wr(SRID_REG_CTRL, 32'h0000_0028);
    wr(SRID_REG_REQ, 32'h0000_0002);
    cyc(8);
    rdChk(SRID_REG_STATUS, 32'hFFFF_0000, 32'h0002_0000);
    chk(32'(posLoads + spdLoads - n), 0);
    specSel <= SRID_SPEC_REG;
    wr(SRID_REG_CTRL, '0);
  endtask
  task automatic setCtrl(input logic [31:0] v);
    wr(SRID_REG_CTRL, v);
    cyc(4);
  endtask
  task automatic tModes;
    setCtrl(32'h0000_0001);
    chk(32'(tlFwd), 32'(INL));
    chk(32'(tlRev), 32'(INL));
    setCtrl(32'h0000_0002);
    chk(32'(propMode), 1);
    chk(32'(tlFwd), 32'(FWD));
    setCtrl(32'h0000_0004);
    chk(32'(altActive), 0);
    setCtrl(32'h0000_0014);
    chk(32'(gainSet), 32'(ALT));
    chk(32'(altActive), 1);
    setCtrl(32'h0000_00C0);
    motion <= 1'b1;
    cyc(4);
    motion <= 1'b0;
    cyc(4);
    chk(32'(propMode), 1);
    chk(32'(tlFwd), 32'(INL));
    motion <= 1'b1;
    cyc(4);
    chk(32'(propMode), 0);
    setCtrl('0);
    chk(32'(gainSet), 32'(BASE));
  endtask
  task automatic clearRun(input logic [3:0] mode, input int exp);
    int a;
    int b;
    droopMode <= mode;
    cyc(2);
    a = dcHigh;
    b = linkHigh;
    wr(SRID_REG_REQ, 32'h0000_0004);
    rdChk(SRID_REG_STATUS, 32'h0000_0040, 32'h0000_0040);
    cyc(HOLD + 8);
    chk(32'(dcHigh - a), 32'(exp));
    chk(32'(linkHigh - b), 32'(HOLD));
  endtask
  task automatic tClear;
    wr(SRID_REG_IRQ_EN, '0);
    wr(SRID_REG_IRQ_CLR, 32'h0000_000F);
    clearRun(SRID_CLR_EDGE, 1);
    chk(32'(irq), 0);
    rdChk(SRID_REG_IRQ_STAT, 32'h0000_0008, 32'h0000_0008);
    wr(SRID_REG_IRQ_EN, 32'h0000_0008);
    cyc(2);
    chk(32'(irq), 1);
    wr(SRID_REG_IRQ_CLR, 32'h0000_0008);
    cyc(2);
    chk(32'(irq), 0);
    clearRun(SRID_CLR_LEVEL, HOLD);
    clearRun(4'h0, 0);
  endtask
  task automatic endSim;
    $display("checks %0d mismatches %0d", checksDone, failCount);
    if (failCount == 0 && checksDone > 0) begin
      $display("Regression OK");
    end else begin
      $display("Regression broken");
    end
    $finish;
  endtask
  initial begin
    #200_000;
    failCount++;
    endSim();
  end
  initial begin
    cyc(16);
    rst_n <= 1'b1;
    cyc(1);
    tReset();
    tPosPoint();
    tRegSource();
    tErrors();
    tModes();
    tClear();
    endSim();
  end
endmodule
